/* File: verilog/scu_pkg.sv */
// Package: register map, field positions, reset values and timing counts for the smart card UART
package scu_pkg;

  // Register word offsets (byte address = 4 * index)
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_BRG = 3'h1;
  localparam logic [2:0] REG_TXBUF = 3'h2;
  localparam logic [2:0] REG_RXBUF = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;

  // Control field positions
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 2;
  localparam int CTRL_DATA_INV = 6;
  localparam int CTRL_ERR_SIG_EN = 7;
  localparam int CTRL_MSB_FIRST = 8;
  localparam int CTRL_PARITY_EN = 9;
  localparam int CTRL_PARITY_ODD = 10;
  localparam int CTRL_POL_REV = 11;
  localparam int CTRL_CLK_SEL_LO = 12;

  // Status field positions
  localparam int STAT_TX_DONE = 0;
  localparam int STAT_TX_EMPTY = 1;
  localparam int STAT_RX_FULL = 2;
  localparam int STAT_RX_DONE = 3;
  localparam int STAT_COLLISION = 4;
  localparam int STAT_OVERRUN = 5;
  localparam int STAT_FRAMING = 6;
  localparam int STAT_PARITY = 7;
  localparam int STAT_ERR_SUM = 8;
  localparam int STAT_RX_AT_TXIRQ = 9;
  localparam int STAT_TX_BUSY = 10;
  localparam int STAT_RX_PIN = 11;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] BRG_RESET = 8'h00;

  // Timing counts
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [3:0] FRAME_BITS_PAR = 4'ha;
  localparam logic [3:0] FRAME_BITS_NOPAR = 4'h9;

  // Prescaled bit clock source selection
  typedef enum logic [1:0] {
    CLK_UNDIVIDED_PERIPHERAL_CLOCK = 2'h0,
    CLK_PERIPHERAL_CLOCK_DIV8 = 2'h1,
    CLK_PERIPHERAL_CLOCK_DIV32 = 2'h2
  } scu_clk_sel_e;

  // Software control word as seen by the serial logic
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic data_inv;
    logic err_sig_en;
    logic msb_first;
    logic parity_en;
    logic parity_odd;
    logic pol_rev;
    logic [1:0] clk_sel;
  } scu_cfg_s;

endpackage

/* File: verilog/scu_top.sv */
// Smart card UART: polarity reversal, collision detection, smart card framing, Avalon slave
// Contract
// RULE_01 - Polarity reversal inverts tx and rx lines
// RULE_02 - Software keeps reversal off normally
// RULE_03 - Collision request when tx and rx differ
// RULE_04 - Software selects 8-bit, one stop bit
// RULE_05 - Direct format: even, plain, LSB first
// RULE_06 - Inverse format: odd, inverted, MSB first
// RULE_07 - Inverse sends bit 7 first, direct bit 0
// RULE_08 - Bit rate is prescaled clock/(16(n+1))
// RULE_09 - Software disables hardware flow control
// RULE_10 - Software picks tx complete interrupt cause
// RULE_11 - Transmit needs enable and loaded buffer
// RULE_12 - Receive needs enable and start bit
// RULE_13 - Tx request when shifting fully completes
// RULE_14 - Rx request when word reaches buffer
// RULE_15 - Overrun overwrites buffer, no rx request
// RULE_16 - Overrun, framing, parity errors, error sum
// RULE_17 - Parity error drives tx pin low
// RULE_18 - Error output moves tx interrupt earlier
// RULE_19 - Rx level latched at tx interrupt
// RULE_20 - Data logic inverts buffer write and read
// RULE_21 - Error low lasts one bit from stop
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

module scu_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_serial_rx_pin,
  output logic o_serial_tx_pin,
  output logic o_tx_irq_req,
  output logic o_rx_irq_req,
  output logic o_collision_irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0] ctrl_q;
  logic [7:0] brg_q;
  logic [7:0] txbuf_q;
  logic tx_empty_q;
  logic [7:0] rxbuf_q;
  logic rx_full_q;
  logic tx_done_q, rx_done_q, coll_q, ovr_q, frm_q, par_q, rx_at_txirq_q;
  logic ack;
  logic [31:0] rdata_q;
  logic wr_ack, rd_ack;
  scu_pkg::scu_cfg_s cfg;
  logic [4:0] pre_cnt_q;
  logic pre_en;
  logic [7:0] brg_cnt_q;
  logic tick;
  logic tx_busy_q;
  logic [3:0] tx_phase_q;
  logic [3:0] tx_idx_q;
  logic [10:0] tx_frame_q;
  logic tx_bit;
  logic tx_load;
  logic tx_last_bit;
  logic tx_irq_set;
  logic tx_pin_d;
  logic rx_line;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} scu_rx_state_e;
  scu_rx_state_e rx_state_q;
  logic [3:0] rx_phase_q;
  logic [3:0] rx_idx_q;
  logic [7:0] rx_shift_q;
  logic rx_par_acc_q;
  logic rx_sample;
  logic rx_word_done, rx_frm_err, rx_par_err;
  logic err_low_q;
  logic [3:0] err_phase_q;
  logic coll_set;
  logic [3:0] last_idx;

  // Reverse the bit order of a byte
  function automatic logic [7:0] scu_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8; k++) begin
      r[k] = v[7 - k];
    end
    return r;
  endfunction

  // Byte-lane merge for a control word write
  function automatic logic [31:0] scu_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: waitrequest held high, dropped for exactly one cycle per access
  // Waitrequest is the flop itself so the bus sees a clean registered level
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
    end
  end

  assign ack = ~o_avs_waitrequest;
  assign wr_ack = i_avs_write & ack;
  assign rd_ack = i_avs_read & ack;

  // Read data registered in the wait cycle, standing at the acknowledge edge
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_avs_read & o_avs_waitrequest) begin
      rdata_q <= 32'h0000_0000;
      unique case (i_avs_address)
        scu_pkg::REG_CTRL: rdata_q <= ctrl_q;
        scu_pkg::REG_BRG: rdata_q[7:0] <= brg_q;
        // Data logic inversion applied on the way out of the receive buffer
        // RULE_20 read inversion
        scu_pkg::REG_RXBUF: rdata_q[7:0] <= rxbuf_q ^ {8{cfg.data_inv}};
        scu_pkg::REG_STATUS: begin
          rdata_q[scu_pkg::STAT_TX_DONE] <= tx_done_q;
          rdata_q[scu_pkg::STAT_TX_EMPTY] <= tx_empty_q;
          rdata_q[scu_pkg::STAT_RX_FULL] <= rx_full_q;
          rdata_q[scu_pkg::STAT_RX_DONE] <= rx_done_q;
          rdata_q[scu_pkg::STAT_COLLISION] <= coll_q;
          rdata_q[scu_pkg::STAT_OVERRUN] <= ovr_q;
          rdata_q[scu_pkg::STAT_FRAMING] <= frm_q;
          rdata_q[scu_pkg::STAT_PARITY] <= par_q;
          // RULE_16 error sum
          rdata_q[scu_pkg::STAT_ERR_SUM] <= ovr_q | frm_q | par_q;
          rdata_q[scu_pkg::STAT_RX_AT_TXIRQ] <= rx_at_txirq_q;
          rdata_q[scu_pkg::STAT_TX_BUSY] <= tx_busy_q;
          rdata_q[scu_pkg::STAT_RX_PIN] <= i_serial_rx_pin;
        end
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign o_avs_readdata = rdata_q;

  // Control and rate generator registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= scu_pkg::CTRL_RESET;
      brg_q <= scu_pkg::BRG_RESET;
    end else if (wr_ack) begin
      if (i_avs_address == scu_pkg::REG_CTRL) begin
        ctrl_q <= scu_merge(ctrl_q, i_avs_writedata, i_avs_byteenable) & 32'h0000_3fc5;
      end
      if (i_avs_address == scu_pkg::REG_BRG && i_avs_byteenable[0]) begin
        brg_q <= i_avs_writedata[7:0];
      end
    end
  end

  assign cfg.tx_en = ctrl_q[scu_pkg::CTRL_TX_EN];
  assign cfg.rx_en = ctrl_q[scu_pkg::CTRL_RX_EN];
  assign cfg.data_inv = ctrl_q[scu_pkg::CTRL_DATA_INV];
  assign cfg.err_sig_en = ctrl_q[scu_pkg::CTRL_ERR_SIG_EN];
  assign cfg.msb_first = ctrl_q[scu_pkg::CTRL_MSB_FIRST];
  assign cfg.parity_en = ctrl_q[scu_pkg::CTRL_PARITY_EN];
  assign cfg.parity_odd = ctrl_q[scu_pkg::CTRL_PARITY_ODD];
  assign cfg.pol_rev = ctrl_q[scu_pkg::CTRL_POL_REV];
  assign cfg.clk_sel = ctrl_q[scu_pkg::CTRL_CLK_SEL_LO +: 2];

  // Transmit buffer; a write while full simply replaces the pending byte
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      txbuf_q <= 8'h00;
      tx_empty_q <= 1'b1;
    end else if (wr_ack && i_avs_address == scu_pkg::REG_TXBUF && i_avs_byteenable[0]) begin
      // RULE_20 write inversion
      txbuf_q <= i_avs_writedata[7:0] ^ {8{cfg.data_inv}};
      tx_empty_q <= 1'b0;
    end else if (tx_load) begin
      tx_empty_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate generation: prescaler then reload counter; tick is the 16x sample rate
  // RULE_08 prescaler select
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pre_cnt_q <= 5'h00;
    end else begin
      pre_cnt_q <= pre_cnt_q + 5'h01;
    end
  end

  always_comb begin
    unique case (cfg.clk_sel)
      scu_pkg::CLK_UNDIVIDED_PERIPHERAL_CLOCK: pre_en = 1'b1;
      scu_pkg::CLK_PERIPHERAL_CLOCK_DIV8: pre_en = pre_cnt_q[2:0] == scu_pkg::DIV8_LAST[2:0];
      scu_pkg::CLK_PERIPHERAL_CLOCK_DIV32: pre_en = pre_cnt_q == scu_pkg::DIV32_LAST;
      default: pre_en = 1'b1;
    endcase
  end

  // RULE_08 divide by n+1
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      brg_cnt_q <= 8'h00;
    end else if (pre_en) begin
      brg_cnt_q <= (brg_cnt_q == 8'h00) ? brg_q : brg_cnt_q - 8'h01;
    end
  end

  assign tick = pre_en & (brg_cnt_q == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  // RULE_11 start condition
  assign tx_load = ~tx_busy_q & cfg.tx_en & ~tx_empty_q;
  assign last_idx = cfg.parity_en ? scu_pkg::FRAME_BITS_PAR : scu_pkg::FRAME_BITS_NOPAR;
  assign tx_last_bit = tick & (tx_phase_q == scu_pkg::TICKS_LAST) & (tx_idx_q == last_idx);

  // Frame built at load: start, data in chosen order, optional parity, stop
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_busy_q <= 1'b0;
      tx_phase_q <= 4'h0;
      tx_idx_q <= 4'h0;
      tx_frame_q <= 11'h7ff;
    end else if (tx_load) begin
      tx_busy_q <= 1'b1;
      tx_phase_q <= 4'h0;
      tx_idx_q <= 4'h0;
      // RULE_07 bit order
      tx_frame_q[8:1] <= cfg.msb_first ? scu_rev8(txbuf_q) : txbuf_q;
      tx_frame_q[0] <= 1'b0;
      tx_frame_q[9] <= cfg.parity_en ? (^txbuf_q) ^ cfg.parity_odd : 1'b1;
      tx_frame_q[10] <= 1'b1;
    end else if (tx_busy_q && tick) begin
      tx_phase_q <= tx_phase_q + 4'h1;
      if (tx_phase_q == scu_pkg::TICKS_LAST) begin
        tx_idx_q <= tx_idx_q + 4'h1;
        if (tx_idx_q == last_idx) begin
          tx_busy_q <= 1'b0;
        end
      end
    end
  end

  // Without parity the stop bit is index 9, so index 10 never shows
  assign tx_bit = tx_busy_q ? tx_frame_q[tx_idx_q] : 1'b1;

  // RULE_13 end of shifting, RULE_18 early when error output enabled
  assign tx_irq_set = cfg.err_sig_en ?
      (tx_busy_q & tick & (tx_idx_q == last_idx) & (tx_phase_q == scu_pkg::SAMPLE_PHASE)) :
      (tx_busy_q & tx_last_bit);

  // Pin: error low overrides the frame; polarity reversal applies to every bit
  // RULE_01 output inversion, RULE_17 error low
  assign tx_pin_d = err_low_q ? 1'b0 : tx_bit ^ cfg.pol_rev;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_serial_tx_pin <= 1'b1;
    end else begin
      o_serial_tx_pin <= tx_pin_d;
    end
  end

  // RULE_03 collision compare at the bit centre while sending
  assign coll_set = tx_busy_q & tick & (tx_phase_q == scu_pkg::SAMPLE_PHASE) &
                    (o_serial_tx_pin != i_serial_rx_pin);

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  // RULE_01 input inversion
  assign rx_line = i_serial_rx_pin ^ cfg.pol_rev;
  assign rx_sample = tick & (rx_phase_q == scu_pkg::SAMPLE_PHASE);
  assign rx_word_done = (rx_state_q == RX_STOP) & rx_sample;
  assign rx_frm_err = ~rx_line;
  assign rx_par_err = cfg.parity_en & (rx_par_acc_q ^ cfg.parity_odd);

  // Start bit rechecked at its centre to reject glitches
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_state_q <= RX_IDLE;
      rx_phase_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_shift_q <= 8'h00;
      rx_par_acc_q <= 1'b0;
    end else begin
      if (tick) begin
        rx_phase_q <= rx_phase_q + 4'h1;
      end
      unique case (rx_state_q)
        RX_IDLE: begin
          // RULE_12 start condition
          if (cfg.rx_en && !rx_line) begin
            rx_state_q <= RX_START;
            rx_phase_q <= 4'h0;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_state_q <= rx_line ? RX_IDLE : RX_BITS;
            rx_idx_q <= 4'h0;
            rx_par_acc_q <= 1'b0;
          end
        end
        RX_BITS: begin
          if (rx_sample) begin
            rx_idx_q <= rx_idx_q + 4'h1;
            rx_par_acc_q <= rx_par_acc_q ^ rx_line;
            if (rx_idx_q < 4'h8) begin
              rx_shift_q <= cfg.msb_first ? {rx_shift_q[6:0], rx_line} :
                                            {rx_line, rx_shift_q[7:1]};
            end
            if (rx_idx_q == last_idx - 4'h2) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer; reading it frees it
  // RULE_14 buffer transfer, RULE_15 overwrite on overrun
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rxbuf_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else if (rx_word_done) begin
      rxbuf_q <= rx_shift_q;
      rx_full_q <= 1'b1;
    end else if (rd_ack && i_avs_address == scu_pkg::REG_RXBUF) begin
      rx_full_q <= 1'b0;
    end
  end

  // Error low for one bit time from the stop sample point
  // RULE_21 one bit pulse
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      err_low_q <= 1'b0;
      err_phase_q <= 4'h0;
    end else if (rx_word_done && cfg.err_sig_en && rx_par_err) begin
      err_low_q <= 1'b1;
      err_phase_q <= 4'h0;
    end else if (err_low_q && tick) begin
      err_phase_q <= err_phase_q + 4'h1;
      if (err_phase_q == scu_pkg::TICKS_LAST) begin
        err_low_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: hardware set wins over software write-one-to-clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_done_q <= 1'b0;
      rx_done_q <= 1'b0;
      coll_q <= 1'b0;
      ovr_q <= 1'b0;
      frm_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      if (wr_ack && i_avs_address == scu_pkg::REG_STATUS && i_avs_byteenable[0]) begin
        tx_done_q <= tx_done_q & ~i_avs_writedata[scu_pkg::STAT_TX_DONE];
        rx_done_q <= rx_done_q & ~i_avs_writedata[scu_pkg::STAT_RX_DONE];
        coll_q <= coll_q & ~i_avs_writedata[scu_pkg::STAT_COLLISION];
        ovr_q <= ovr_q & ~i_avs_writedata[scu_pkg::STAT_OVERRUN];
        frm_q <= frm_q & ~i_avs_writedata[scu_pkg::STAT_FRAMING];
        par_q <= par_q & ~i_avs_writedata[scu_pkg::STAT_PARITY];
      end
      if (tx_irq_set) begin
        tx_done_q <= 1'b1;
      end
      if (rx_word_done && !rx_full_q) begin
        rx_done_q <= 1'b1;
      end
      if (coll_set) begin
        coll_q <= 1'b1;
      end
      // RULE_16 error detection
      if (rx_word_done) begin
        if (rx_full_q) begin
          ovr_q <= 1'b1;
        end
        if (rx_frm_err) begin
          frm_q <= 1'b1;
        end
        if (rx_par_err) begin
          par_q <= 1'b1;
        end
      end
    end
  end

  // RULE_19 card error level captured at transmit interrupt
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_at_txirq_q <= 1'b1;
    end else if (tx_irq_set) begin
      rx_at_txirq_q <= rx_line;
    end
  end

  // Request pulses, one cycle each; overrun suppresses the receive request
  // RULE_03 collision request, RULE_13 tx request, RULE_15 no rx request on overrun
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_tx_irq_req <= 1'b0;
      o_rx_irq_req <= 1'b0;
      o_collision_irq_req <= 1'b0;
    end else begin
      o_tx_irq_req <= tx_irq_set;
      o_rx_irq_req <= rx_word_done & ~rx_full_q;
      o_collision_irq_req <= coll_set;
    end
  end

endmodule

`default_nettype wire

/* File: test/scu_top_checker.sv */
// Checker: bus handshake, reset and interrupt pulse properties
`timescale 1ns/100ps
`default_nettype none
module scu_top_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_serial_rx_pin,
  input wire logic o_serial_tx_pin,
  input wire logic o_tx_irq_req,
  input wire logic o_rx_irq_req,
  input wire logic o_collision_irq_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Request seen, then one answer cycle
  sequence s_req_seen;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_ack;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  AST_WAIT_ONE: assert property (s_req_seen |=> s_ack)
    else $error("bus answer not one wait state");
  AST_NO_IDLE_ACK: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> o_avs_waitrequest) else $error("answer without request");
  AST_READ_ZERO: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address > 3'h4
    |-> o_avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
  // Reset must not be masked by itself
  AST_RESET_QUIET: assert property (@(posedge i_clk) disable iff (1'b0) i_sys_rst |=>
    o_avs_waitrequest && o_serial_tx_pin && !o_tx_irq_req && !o_rx_irq_req
    && !o_collision_irq_req) else $error("outputs busy after reset");
  AST_TX_PULSE: assert property (o_tx_irq_req |=> !o_tx_irq_req)
    else $error("tx request longer than one cycle");
  AST_RX_PULSE: assert property (o_rx_irq_req |=> !o_rx_irq_req)
    else $error("rx request longer than one cycle");
  AST_COLL_PULSE: assert property (o_collision_irq_req |=> !o_collision_irq_req)
    else $error("collision request longer than one cycle");
  AST_COLL_CAUSE: assert property (o_collision_irq_req |->
    $past(o_serial_tx_pin != i_serial_rx_pin)) else $error("collision with equal lines");
endmodule
bind scu_top scu_top_checker i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_serial_rx_pin(i_serial_rx_pin), .o_serial_tx_pin(o_serial_tx_pin),
  .o_tx_irq_req(o_tx_irq_req), .o_rx_irq_req(o_rx_irq_req),
  .o_collision_irq_req(o_collision_irq_req));
`default_nettype wire

/* File: test/scu_card.sv */
// Card model: open-drain driver on the pulled-up shared data line
`timescale 1ns/100ps
`default_nettype none
module scu_card (
  input wire logic i_clk,
  output logic o_pull_low
);
  initial begin
    o_pull_low = 1'b0;
  end
  // direct frame, bc clocks a bit
  task automatic send(input logic [7:0] b, input logic bad, input int bc);
    logic [10:0] f;
    f = {1'b1, (^b) ^ bad, b, 1'b0};
    for (int k = 0; k < 11; k++) begin
      @(posedge i_clk);
      o_pull_low <= !f[k];
      repeat (bc - 1) @(posedge i_clk);
    end
  endtask
  // card flags a bad frame by holding the line low
  task automatic pull(input int len);
    @(posedge i_clk);
    o_pull_low <= 1'b1;
    repeat (len) @(posedge i_clk);
    o_pull_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/smart_card_uart_extensions_bench.sv */
// Bench: register, frame, error and collision traffic for the smart card UART
`timescale 1ns/100ps
`default_nettype none
module smart_card_uart_extensions_bench;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [2:0] i_avs_address = 3'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  wire [31:0] o_avs_readdata;
  wire o_avs_waitrequest, o_serial_tx_pin, o_tx_irq_req, o_rx_irq_req, o_collision_irq_req;
  wire card_pull;
  // Pulled-up line: either side may pull it low
  wire line = o_serial_tx_pin & ~card_pull;
  int n_mismatch = 0;
  int n_compared = 0;
  int tx_cnt = 0;
  int rx_cnt = 0;
  int coll_cnt = 0;
  always #2 i_clk = ~i_clk;
  scu_top i_scu_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_serial_rx_pin(line),
    .o_serial_tx_pin(o_serial_tx_pin), .o_tx_irq_req(o_tx_irq_req),
    .o_rx_irq_req(o_rx_irq_req), .o_collision_irq_req(o_collision_irq_req));
  scu_card i_scu_card (.i_clk(i_clk), .o_pull_low(card_pull));
  // Pulse counters, updated late so readers at the edge see old counts
  always @(posedge i_clk) begin
    if (o_tx_irq_req === 1'b1) tx_cnt <= tx_cnt + 1;
    if (o_rx_irq_req === 1'b1) rx_cnt <= rx_cnt + 1;
    if (o_collision_irq_req === 1'b1) coll_cnt <= coll_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge i_clk);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    for (i = 0; i < 16; i++) begin
      @(posedge i_clk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (i == 16) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic wait_start(input logic lvl);
    int i;
    for (i = 0; i < 40000; i++) begin
      @(posedge i_clk);
      if (o_serial_tx_pin === lvl) break;
    end
    if (i == 40000) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  function automatic logic [10:0] frame(input logic [7:0] b, input logic inv, input logic pol);
    logic [7:0] s;
    logic [7:0] r;
    s = b ^ {8{inv}};
    for (int k = 0; k < 8; k++) r[k] = inv ? s[7 - k] : s[k];
    return {1'b1, (^s) ^ inv, r, 1'b0} ^ {11{pol}};
  endfunction
  // clocks a bit for source and divider
  function automatic int bclk(input int sel, input int n);
    return 16 * (sel == 0 ? 1 : (sel == 1 ? 8 : 32)) * (n + 1);
  endfunction
  function automatic logic [31:0] cfg(input logic inv, input logic pol, input logic err,
                                      input logic [1:0] sel);
    return 32'h0000_0205 | {18'h0, sel, pol, inv, 1'b0, inv, err, inv, 6'h0};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q, c;
    logic [10:0] f;
    logic [7:0] b, b2;
    int bc, n, t0, r0, c0;
    logic inv, pol;
    void'($urandom(32'hecc3c8ca));
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    // Reset values, reserved bits and an unmapped place
    bus(0, 3'h0, 0, q); check(q, 32'h0);
    bus(0, 3'h1, 0, q); check(q, 32'h0);
    bus(0, 3'h4, 0, q); check(q & 32'h0000_0e07, 32'h0000_0a02);
    bus(1, 3'h0, 32'hffff_fffa, q);
    bus(0, 3'h0, 0, q); check(q, 32'h0000_3fc0);
    bus(1, 3'h6, $urandom, q);
    bus(0, 3'h6, 0, q); check(q, 32'h0);
    // Transmit over every source and both formats, looped back
    for (int i = 0; i < 6; i++) begin
      inv = i[0];
      pol = (i == 4);
      n = $urandom_range(1, 0);
      bc = bclk(i % 3, n);
      b = (i < 2) ? {8{i[0]}} : 8'($urandom);
      c = cfg(inv, pol, 1'b0, 2'(i % 3));
      f = frame(b, inv, pol);
      bus(1, 3'h1, n, q);
      bus(1, 3'h0, c & ~32'h0000_0005, q);
      bus(1, 3'h2, b, q);
      repeat (40) @(posedge i_clk);
      check(o_serial_tx_pin, !pol);
      t0 = tx_cnt;
      r0 = rx_cnt;
      c0 = coll_cnt;
      bus(1, 3'h0, c, q);
      wait_start(pol);
      repeat (bc / 2) @(posedge i_clk);
      for (int k = 0; k < 11; k++) begin
        check(o_serial_tx_pin, f[k]);
        if (k < 10) repeat (bc) @(posedge i_clk);
      end
      check(tx_cnt, t0);
      repeat (bc) @(posedge i_clk);
      check(tx_cnt, t0 + 1);
      check(rx_cnt, r0 + 1);
      check(coll_cnt, c0);
      bus(0, 3'h4, 0, q);
      check(q & 32'h0000_0208, 32'h0000_0208);
      bus(0, 3'h3, 0, q);
      check(q[7:0], b);
      bus(1, 3'h4, 32'h0000_00f9, q);
    end
    // Card frames: overrun, then a bad parity with error signal
    bus(1, 3'h1, 0, q);
    bus(1, 3'h0, cfg(1'b0, 1'b0, 1'b1, 2'h0) & ~32'h0000_0001, q);
    r0 = rx_cnt;
    b = $urandom;
    b2 = ~b;
    i_scu_card.send(b, 1'b0, 16);
    i_scu_card.send(b2, 1'b0, 16);
    repeat (4) @(posedge i_clk);
    check(rx_cnt, r0 + 1);
    bus(0, 3'h4, 0, q);
    check(q & 32'h0000_01e0, 32'h0000_0120);
    bus(0, 3'h3, 0, q);
    check(q[7:0], b2);
    bus(1, 3'h4, 32'h0000_00f9, q);
    i_scu_card.send(b, 1'b1, 16);
    check(o_serial_tx_pin, 1'b0);
    repeat (16) @(posedge i_clk);
    check(o_serial_tx_pin, 1'b1);
    bus(0, 3'h4, 0, q);
    check(q & 32'h0000_0180, 32'h0000_0180);
    // Receiver off ignores a frame; the own error low may start a stray one
    bus(1, 3'h0, 0, q);
    repeat (200) @(posedge i_clk);
    bus(1, 3'h4, 32'h0000_00f9, q);
    // Free the buffer so a wrongly taken frame would raise a request
    bus(0, 3'h3, 0, q);
    r0 = rx_cnt;
    i_scu_card.send(b, 1'b0, 16);
    repeat (20) @(posedge i_clk);
    check(rx_cnt, r0);
    // Card answers our frame with an error low across the stop bit
    bus(1, 3'h0, cfg(1'b0, 1'b0, 1'b1, 2'h0), q);
    t0 = tx_cnt;
    c0 = coll_cnt;
    bus(1, 3'h2, 32'h0000_00ff, q);
    wait_start(1'b0);
    // Low pulse centred on the stop bit sample point
    repeat (160) @(posedge i_clk);
    i_scu_card.pull(10);
    check(tx_cnt, t0 + 1);
    check(coll_cnt > c0, 1'b1);
    bus(0, 3'h4, 0, q);
    check(q & 32'h0000_0210, 32'h0000_0010);
    stop_test();
  end
endmodule
`default_nettype wire
